// *** cele_engine.sv ***
// Purpose: event table evaluation engine driving output channel events
// Assumes: inputs synchronous to ref_clk; time of day in seconds
// Notes:   one slot evaluated per cycle, full table once per tick
// Operation
// - 512 configurable slots, typed or unused
// - follow mirrors input on/off conditions
// - toggle flips state on each press
// - AND true when all references true
// - OR true when any reference true
// - NOR false when any reference true
// - XOR true when exactly one true
// - NOT inverts its single reference
// - flash alternates on/off times from start
// - delay-on waits condition hold time
// - delay-off holds true after condition drops
// - reset restarts only faulted channels
// - warning lamp on when any fault
// - clock event follows time-of-day window
// - always-on event is true unconditionally
// - tri-state code from events A and B
// - B selects 5 V, with or without A
// - two wiper channels stop at park
// - wiper runs on until park after trigger
// - event flash/delay take trigger from event
// - event wiper triggered by an event
// - six comparison relations on source value
// - stale CAN source applies loss action
`timescale 1ns/1ns
module cele_engine #(
	parameter int TICK_CYCLES = cele_pkg::TICK_CYC
) (
	input  wire logic                          ref_clk,
	input  wire logic                          rstn,
	input  wire logic                          cfgWe,
	input  wire logic [cele_pkg::EVW-1:0]      cfgAddr,
	input  wire cele_pkg::cele_cfg_t           cfgData,
	input  wire logic [cele_pkg::NSRC-1:0][cele_pkg::VALW-1:0] srcVal,
	input  wire logic [cele_pkg::NSRC-1:0]     srcFresh,
	input  wire logic [cele_pkg::NCH-1:0]      faultIn,
	input  wire logic [16:0]                   timeOfDay,
	output logic [cele_pkg::NEV-1:0]           evState,
	output logic [cele_pkg::NTRI-1:0][1:0]     triLevel,
	output logic [cele_pkg::NWIPE-1:0]         wiperRun,
	output logic                               warnLamp,
	output logic [cele_pkg::NCH-1:0]           faultRestart,
	output logic                               scanBusy
);
	// ----------------------------------------------------------------
	// storage
	// ----------------------------------------------------------------
	cele_pkg::cele_cfg_t cfgMem [cele_pkg::NEV];
	logic [cele_pkg::VALW-1:0] cnt_r [cele_pkg::NEV];
	logic [cele_pkg::NEV-1:0]  valid_r;
	logic [cele_pkg::NEV-1:0]  evState_r;
	logic [cele_pkg::NEV-1:0]  aux_r;
	logic [cele_pkg::NSRC-1:0][cele_pkg::VALW-1:0] age_r;
	logic [cele_pkg::NTRI-1:0][1:0] triLevel_r;
	logic [cele_pkg::NWIPE-1:0] wiperRun_r;
	logic                       warnLamp_r;
	logic [cele_pkg::NCH-1:0]   faultRestart_r;
	logic [31:0]                tickCnt_r;
	logic                       tickEn;
	logic                       scanBusy_r;
	logic [cele_pkg::EVW-1:0]   scanIdx_r;

	assign evState      = evState_r;
	assign triLevel     = triLevel_r;
	assign wiperRun     = wiperRun_r;
	assign warnLamp     = warnLamp_r;
	assign faultRestart = faultRestart_r;
	assign scanBusy     = scanBusy_r;

	function automatic logic relHit(input cele_pkg::cele_rel_t op,
		input logic [15:0] a, input logic [15:0] b);
		unique case (op)
			cele_pkg::R_EQ: relHit = (a == b);
			cele_pkg::R_LT: relHit = (a < b);
			cele_pkg::R_GT: relHit = (a > b);
			cele_pkg::R_LE: relHit = (a <= b);
			cele_pkg::R_GE: relHit = (a >= b);
			cele_pkg::R_NE: relHit = (a != b);
			default:        relHit = 1'b0;
		endcase
	endfunction

	// ----------------------------------------------------------------
	// tick divider and scan sequencer
	// ----------------------------------------------------------------
	always_ff @(posedge ref_clk) begin
		if (!rstn || tickEn)
			tickCnt_r <= '0;
		else
			tickCnt_r <= tickCnt_r + 32'h00000001;
	end
	assign tickEn = (tickCnt_r == 32'(TICK_CYCLES - 1));

	// a tick landing mid-scan is dropped; scan is far shorter than a tick
	always_ff @(posedge ref_clk) begin
		if (!rstn) begin
			scanBusy_r <= 1'b0;
			scanIdx_r  <= '0;
		end else if (!scanBusy_r) begin
			scanBusy_r <= tickEn;
			scanIdx_r  <= '0;
		end else begin
			scanIdx_r <= scanIdx_r + 9'h001;
			if (scanIdx_r == 9'(cele_pkg::NEV - 1))
				scanBusy_r <= 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// configuration table
	// ----------------------------------------------------------------
	always_ff @(posedge ref_clk) begin
		if (cfgWe)
			cfgMem[cfgAddr] <= cfgData;
	end
	always_ff @(posedge ref_clk) begin
		if (!rstn)
			valid_r <= '0;
		else if (cfgWe)
			valid_r[cfgAddr] <= 1'b1;
	end

	// ----------------------------------------------------------------
	// per-source refresh age in ms
	// ----------------------------------------------------------------
	genvar gs;
	generate
		for (gs = 0; gs < cele_pkg::NSRC; gs++) begin : g_age
			always_ff @(posedge ref_clk) begin
				if (!rstn || srcFresh[gs])
					age_r[gs] <= '0;
				else if (tickEn && age_r[gs] != '1)
					age_r[gs] <= age_r[gs] + cele_pkg::ONE;
			end
		end
	endgenerate

	// ----------------------------------------------------------------
	// slot evaluation
	// ----------------------------------------------------------------
	cele_pkg::cele_cfg_t c;
	logic [cele_pkg::VALW-1:0] sv, cnt, cntInc, cntNxt;
	logic [cele_pkg::NREF-1:0] rv;
	logic [2:0] ones;
	logic st, aux, onHit, offHit, stale, inLvl, trig, stNxt, inWin;
	logic [1:0] lvl;

	always_comb begin
		c      = cfgMem[scanIdx_r];
		st     = evState_r[scanIdx_r];
		aux    = aux_r[scanIdx_r];
		// timer memory has no reset: a fresh start counts from zero
		cnt    = (aux | st) ? cnt_r[scanIdx_r] : '0;
		cntInc = cnt + cele_pkg::ONE;
		sv     = (c.src == cele_pkg::SRC_LAMP) ?
			(warnLamp_r ? cele_pkg::LAMP_ON : '0) : srcVal[c.src];
		onHit  = relHit(c.onRel, sv, c.onVal);
		offHit = relHit(c.offRel, sv, c.offVal);
		// the lamp index sits inside the can range (at or above CAN_BASE) but is never refreshed
		stale  = (c.src >= cele_pkg::CAN_BASE) &&
			(c.src != cele_pkg::SRC_LAMP) &&
			(age_r[c.src] >= c.lossMs);
		if (stale) begin
			unique case (c.lossAct)
				cele_pkg::L_ON:  inLvl = 1'b1;
				cele_pkg::L_OFF: inLvl = 1'b0;
				default:         inLvl = aux;
			endcase
		end else begin
			inLvl = onHit ? 1'b1 : (offHit ? 1'b0 : aux);
		end
		for (int k = 0; k < cele_pkg::NREF; k++)
			rv[k] = c.refEn[k] & evState_r[c.refs[k]];
		ones = 3'(rv[0]) + 3'(rv[1]) + 3'(rv[2]) + 3'(rv[3]) + 3'(rv[4]);
		trig = (c.kind >= cele_pkg::T_EFLASH) ?
			evState_r[c.refs[0]] : inLvl;
		inWin = (c.clkOn <= c.clkOff) ?
			(timeOfDay >= c.clkOn && timeOfDay < c.clkOff) :
			(timeOfDay >= c.clkOn || timeOfDay < c.clkOff);
		lvl    = rv[1] ? cele_pkg::LVL_5V :
			(rv[0] ? cele_pkg::LVL_2V5 : cele_pkg::LVL_0V);
		stNxt  = 1'b0;
		cntNxt = '0;
		unique case (c.kind)
			cele_pkg::T_FOLLOW: stNxt = trig;
			cele_pkg::T_TOGGLE: stNxt = st ^ (trig & ~aux);
			cele_pkg::T_AND: stNxt = (c.refEn != '0) && (rv == c.refEn);
			cele_pkg::T_OR:  stNxt = (ones != 3'h0);
			cele_pkg::T_NOR: stNxt = (ones == 3'h0);
			cele_pkg::T_XOR: stNxt = (ones == 3'h1);
			cele_pkg::T_NOT: stNxt = ~evState_r[c.refs[0]];
			cele_pkg::T_FLASH, cele_pkg::T_EFLASH: begin
				if (!trig) begin
					stNxt = 1'b0;
				end else if (!aux) begin
					stNxt = c.startOn;
				end else if (cntInc >= (st ? c.onMs : c.offMs)) begin
					stNxt = ~st;
				end else begin
					stNxt  = st;
					cntNxt = cntInc;
				end
			end
			cele_pkg::T_DLYON, cele_pkg::T_EDLYON: begin
				if (trig && (st || cntInc >= c.onMs)) begin
					stNxt = 1'b1;
				end else if (trig) begin
					cntNxt = cntInc;
				end
			end
			cele_pkg::T_DLYOFF, cele_pkg::T_EDLYOFF: begin
				if (trig) begin
					stNxt = 1'b1;
				end else if (st && cntInc < c.offMs) begin
					stNxt  = 1'b1;
					cntNxt = cntInc;
				end
			end
			cele_pkg::T_RESET:  stNxt = trig;
			cele_pkg::T_CLOCK:  stNxt = inWin;
			cele_pkg::T_ALWAYS: stNxt = 1'b1;
			cele_pkg::T_TRI:    stNxt = (lvl != cele_pkg::LVL_0V);
			// park stop only ends the run once the trigger has gone
			cele_pkg::T_WIPER, cele_pkg::T_EWIPER:
				stNxt = trig | (st & ~rv[1]);
			default: stNxt = 1'b0;
		endcase
		if (!valid_r[scanIdx_r])
			stNxt = 1'b0;
	end

	// ----------------------------------------------------------------
	// state write-back
	// ----------------------------------------------------------------
	always_ff @(posedge ref_clk) begin
		if (!rstn) begin
			evState_r <= '0;
			aux_r     <= '0;
		end else if (scanBusy_r) begin
			evState_r[scanIdx_r] <= stNxt;
			aux_r[scanIdx_r]     <= trig & valid_r[scanIdx_r];
		end
	end
	always_ff @(posedge ref_clk) begin
		if (scanBusy_r)
			cnt_r[scanIdx_r] <= cntNxt;
	end

	// ----------------------------------------------------------------
	// channel side effects
	// ----------------------------------------------------------------
	always_ff @(posedge ref_clk) begin
		if (!rstn) begin
			triLevel_r <= '0;
			wiperRun_r <= '0;
		end else if (scanBusy_r && valid_r[scanIdx_r]) begin
			if (c.kind == cele_pkg::T_TRI)
				triLevel_r[c.chan] <= lvl;
			if (c.kind == cele_pkg::T_WIPER || c.kind == cele_pkg::T_EWIPER)
				wiperRun_r[c.chan[0]] <= stNxt;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!rstn)
			warnLamp_r <= 1'b0;
		else
			warnLamp_r <= |faultIn;
	end

	// healthy channels never see a restart pulse
	always_ff @(posedge ref_clk) begin
		if (!rstn)
			faultRestart_r <= '0;
		else if (scanBusy_r && valid_r[scanIdx_r] &&
			c.kind == cele_pkg::T_RESET && stNxt)
			faultRestart_r <= faultIn;
		else
			faultRestart_r <= '0;
	end

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rstn);

	logic evalOn;
	assign evalOn = scanBusy_r && valid_r[scanIdx_r];

	a_lamp_fault: assert property (faultIn != '0 |=> warnLamp_r)
		else $error("lamp off with fault present");
	a_restart_healthy: assert property (
		(faultRestart_r & ~$past(faultIn)) == '0)
		else $error("restart on healthy channel");
	a_scan_len: assert property (
		$rose(scanBusy_r) |-> ##[512:512] !scanBusy_r)
		else $error("scan length wrong");
	a_always_on: assert property (evalOn &&
		c.kind == cele_pkg::T_ALWAYS |=> evState_r[$past(scanIdx_r)])
		else $error("always-on event false");
	a_not_gate: assert property (evalOn && c.kind == cele_pkg::T_NOT &&
		c.refs[0] != scanIdx_r |=>
		evState_r[$past(scanIdx_r)] != $past(evState_r[c.refs[0]]))
		else $error("not gate wrong");
	a_tri_high: assert property (evalOn && c.kind == cele_pkg::T_TRI &&
		rv[1] |=> triLevel_r[$past(c.chan)] == cele_pkg::LVL_5V)
		else $error("tri-state not 5 V with B");
	a_dlyon_off: assert property (evalOn && c.kind == cele_pkg::T_DLYON &&
		!trig |=> !evState_r[$past(scanIdx_r)])
		else $error("delay-on true without condition");
	a_nor_gate: assert property (evalOn && c.kind == cele_pkg::T_NOR &&
		ones != 3'h0 |=> !evState_r[$past(scanIdx_r)])
		else $error("nor true with input true");
	a_unused_slot: assert property (scanBusy_r && !valid_r[scanIdx_r]
		|=> !evState_r[$past(scanIdx_r)])
		else $error("unused slot true");

	c_flash_flip: cover property (evalOn && c.kind == cele_pkg::T_FLASH
		&& aux && trig && stNxt != st);
	c_wiper_park: cover property (evalOn && c.kind == cele_pkg::T_WIPER
		&& !trig && st && rv[1]);
	c_can_stale: cover property (evalOn && stale);
	c_restart: cover property (faultRestart_r != '0);
endmodule // cele_engine

// *** cele_pkg.sv ***
// Purpose: shared constants and types of the event logic engine
// Assumes: one 125 MHz clock, 1 ms evaluation tick
// Notes:   event codes follow the order of the strategy list
package cele_pkg;
	// ----------------------------------------------------------------
	// sizes
	// ----------------------------------------------------------------
	localparam int NEV    = 512;
	localparam int EVW    = 9;
	localparam int NSRC   = 64;
	localparam int SRCW   = 6;
	localparam int VALW   = 16;
	localparam int NCH    = 32;
	localparam int NTRI   = 4;
	localparam int NWIPE  = 2;
	localparam int NREF   = 5;
	localparam logic [SRCW-1:0] CAN_BASE = 6'h20;
	localparam logic [SRCW-1:0] SRC_LAMP = 6'h3f;
	localparam logic [VALW-1:0] LAMP_ON  = 16'h0002;
	localparam logic [VALW-1:0] ONE      = 16'h0001;
	localparam logic [16:0] DAY_ZERO = 17'h00000;
	// ----------------------------------------------------------------
	// timing
	// ----------------------------------------------------------------
	localparam int CLK_HZ  = 125000000;
	localparam int TICK_MS = 1;
	localparam int TICK_CYC = CLK_HZ / 1000 * TICK_MS;
	// ----------------------------------------------------------------
	// encodings
	// ----------------------------------------------------------------
	typedef enum logic [4:0] {
		T_UNUSED = 5'h00, T_FOLLOW = 5'h01, T_TOGGLE = 5'h02,
		T_AND = 5'h03, T_OR = 5'h04, T_NOR = 5'h05, T_XOR = 5'h06,
		T_NOT = 5'h07, T_FLASH = 5'h08, T_DLYON = 5'h09,
		T_DLYOFF = 5'h0a, T_CNT = 5'h0b, T_SEQCNT = 5'h0c,
		T_RESET = 5'h0d, T_CLOCK = 5'h0e, T_ALWAYS = 5'h0f,
		T_TRI = 5'h10, T_WIPER = 5'h11, T_EFLASH = 5'h12,
		T_EDLYON = 5'h13, T_EDLYOFF = 5'h14, T_EWIPER = 5'h15
	} cele_type_t;
	typedef enum logic [2:0] {
		R_EQ = 3'h0, R_LT = 3'h1, R_GT = 3'h2,
		R_LE = 3'h3, R_GE = 3'h4, R_NE = 3'h5
	} cele_rel_t;
	typedef enum logic [1:0] {
		L_HOLD = 2'h0, L_OFF = 2'h1, L_ON = 2'h2
	} cele_loss_t;
	localparam logic [1:0] LVL_0V  = 2'h0;
	localparam logic [1:0] LVL_2V5 = 2'h1;
	localparam logic [1:0] LVL_5V  = 2'h2;
	// ----------------------------------------------------------------
	// one event slot
	// ----------------------------------------------------------------
	typedef struct packed {
		cele_type_t            kind;
		logic [SRCW-1:0]       src;
		cele_rel_t             onRel;
		logic [VALW-1:0]       onVal;
		cele_rel_t             offRel;
		logic [VALW-1:0]       offVal;
		logic [NREF-1:0]       refEn;
		logic [NREF-1:0][EVW-1:0] refs;
		logic [VALW-1:0]       onMs;
		logic [VALW-1:0]       offMs;
		logic                  startOn;
		cele_loss_t            lossAct;
		logic [VALW-1:0]       lossMs;
		logic [16:0]           clkOn;
		logic [16:0]           clkOff;
		logic [1:0]            chan;
	} cele_cfg_t;
endpackage

// *** cele_far_side.sv ***
// Purpose: far side model: one can message source and latched output faults
// Assumes: one message source at the first can index
// Notes:   a restarted channel stays faulted while its cause persists
`timescale 1ns/1ns
module cele_far_side #(
	parameter int MSG_GAP = 100
) (
	input  wire logic                     ref_clk,
	input  wire logic                     canAlive,
	input  wire logic [cele_pkg::NCH-1:0] faultSet,
	input  wire logic [cele_pkg::NCH-1:0] faultRestart,
	output logic [cele_pkg::NSRC-1:0]     srcFresh,
	output logic [cele_pkg::NCH-1:0]      faultIn
);
	int gapCnt = 0;
	initial begin
		srcFresh = '0;
		faultIn = '0;
	end
	// messages stop when the link is lost, so the source goes stale
	always @(posedge ref_clk) begin
		gapCnt <= (gapCnt == MSG_GAP - 1) ? 0 : gapCnt + 1;
		srcFresh <= '0;
		if (canAlive && gapCnt == 0)
			srcFresh[cele_pkg::CAN_BASE] <= 1'b1;
	end
	// a restart only clears a fault whose cause is gone
	always @(posedge ref_clk)
		faultIn <= faultSet | (faultIn & ~faultRestart);
endmodule // cele_far_side

// *** cele_engine_tb_top.sv ***
// Purpose: self-checking bench of the event engine over eight ticks
// Assumes: short tick period so the run stays brief
// Notes:   expectations queued per tick, checked when the scan ends
`timescale 1ns/1ns
`define CHK(nm, ex, gt) begin samples_checked++; if ((gt) !== (ex)) begin \
	error_cnt++; $display("wrong value %s expected %0h seen %0h", nm, ex, \
	gt); end end
module cele_engine_tb_top;
	typedef struct {
		int         idx;
		logic [1:0] val;
	} cele_note_t;
	logic                                          ref_clk = 1'b0;
	logic                                          rstn = 1'b0;
	logic                                          cfgWe = 1'b0;
	logic [cele_pkg::EVW-1:0]                      cfgAddr = '0;
	cele_pkg::cele_cfg_t                           cfgData = '0;
	logic [cele_pkg::NSRC-1:0][cele_pkg::VALW-1:0] srcVal = '0;
	logic [cele_pkg::NSRC-1:0]                     srcFresh;
	logic [cele_pkg::NCH-1:0]                      faultIn, faultRestart;
	logic [cele_pkg::NCH-1:0]                      faultSet = '0;
	logic [16:0]                                   timeOfDay = '0;
	logic [cele_pkg::NEV-1:0]                      evState;
	logic [cele_pkg::NTRI-1:0][1:0]                triLevel;
	logic [cele_pkg::NWIPE-1:0]                    wiperRun;
	logic                                          warnLamp, scanBusy;
	logic                                          busyD = 1'b0;
	logic                                          canAlive = 1'b1;
	int                                            error_cnt = 0;
	int                                            samples_checked = 0;
	int                                            seed = 32'he692;
	cele_note_t                                    notes[$];
	logic [cele_pkg::NCH-1:0]                      rstQ[$];
	cele_pkg::cele_cfg_t                           cfg[26];
	int s0, s1, dc, oc, fp;
	logic a, b, tg, p2, s2, s3, s4, s5, seen, dOff, fl, wr;

	always #4 ref_clk = ~ref_clk;

	cele_engine #(.TICK_CYCLES(600)) i_cele_engine (.ref_clk(ref_clk),
		.rstn(rstn), .cfgWe(cfgWe), .cfgAddr(cfgAddr), .cfgData(cfgData),
		.srcVal(srcVal), .srcFresh(srcFresh), .faultIn(faultIn),
		.timeOfDay(timeOfDay), .evState(evState), .triLevel(triLevel),
		.wiperRun(wiperRun), .warnLamp(warnLamp),
		.faultRestart(faultRestart), .scanBusy(scanBusy));
	cele_far_side i_cele_far_side (.ref_clk(ref_clk), .canAlive(canAlive),
		.faultSet(faultSet), .faultRestart(faultRestart),
		.srcFresh(srcFresh), .faultIn(faultIn));

	task automatic finish_test();
		$display("comparisons %0d mismatches %0d", samples_checked, error_cnt);
		if (error_cnt == 0 && samples_checked > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	function automatic cele_pkg::cele_cfg_t mk(cele_pkg::cele_type_t k,
		logic [5:0] s, logic [4:0] en, int r0, int r1, int t);
		cele_pkg::cele_cfg_t c;
		c = '0;
		c.kind = k;
		c.src = s;
		c.onRel = cele_pkg::R_GE;
		c.onVal = cele_pkg::ONE;
		c.offRel = cele_pkg::R_EQ;
		c.refEn = en;
		c.refs[0] = 9'(r0);
		c.refs[1] = 9'(r1);
		c.onMs = 16'(t);
		c.offMs = 16'(t);
		c.startOn = 1'b1;
		c.lossAct = cele_pkg::L_ON;
		c.lossMs = 16'h0002;
		c.clkOn = 17'h0000a;
		c.clkOff = 17'h00014;
		return c;
	endfunction

	function automatic logic cmp(int r, int v);
		case (r)
			0: return v == 2;
			1: return v < 2;
			2: return v > 2;
			3: return v <= 2;
			4: return v >= 2;
			default: return v != 2;
		endcase
	endfunction

	function automatic logic [1:0] got(int i);
		if (i == 512)
			return {1'b0, warnLamp};
		if (i == 513)
			return triLevel[0];
		if (i == 514)
			return {1'b0, wiperRun[0]};
		return {1'b0, evState[i]};
	endfunction

	task automatic push(int i, logic [1:0] v);
		cele_note_t n;
		n.idx = i;
		n.val = v;
		notes.push_back(n);
	endtask

	task automatic wait_busy(logic lvl);
		int n;
		n = 0;
		while (scanBusy !== lvl) begin
			@(negedge ref_clk);
			n++;
			if (n > 1000) begin
				error_cnt++;
				finish_test();
			end
		end
	endtask

	// ----------------------------------------------------------------
	// watcher: results appear at scan end and as restart pulses
	// ----------------------------------------------------------------
	always @(negedge ref_clk) begin
		cele_note_t nt;
		logic [cele_pkg::NCH-1:0] rq;
		busyD <= scanBusy;
		if (busyD && !scanBusy) begin
			while (notes.size() > 0) begin
				nt = notes.pop_front();
				`CHK($sformatf("slot %0d", nt.idx), nt.val, got(nt.idx))
			end
		end
		if (faultRestart !== '0) begin
			rq = (rstQ.size() > 0) ? rstQ.pop_front() : '0;
			`CHK("restart", rq, faultRestart)
		end
	end

	// ----------------------------------------------------------------
	// driver
	// ----------------------------------------------------------------
	initial begin
		{tg, p2, seen, wr, dc, oc, fp} = '0;
		// one event per output; the lamp feeds the fault reset slot
		cfg[0] = mk(cele_pkg::T_FOLLOW, 0, 0, 0, 0, 0);
		cfg[1] = mk(cele_pkg::T_FOLLOW, 1, 0, 0, 0, 0);
		for (int i = 2; i < 7; i++)
			cfg[i] = mk(cele_pkg::cele_type_t'(i + 1), 0, 5'h03, 0, 1, 0);
		cfg[6].refEn = 5'h01;
		cfg[7] = mk(cele_pkg::T_ALWAYS, 0, 0, 0, 0, 0);
		cfg[8] = mk(cele_pkg::T_TRI, 0, 5'h03, 0, 1, 0);
		cfg[9] = mk(cele_pkg::T_TOGGLE, 2, 0, 0, 0, 0);
		cfg[10] = mk(cele_pkg::T_DLYON, 3, 0, 0, 0, 3);
		cfg[11] = mk(cele_pkg::T_DLYOFF, 3, 0, 0, 0, 3);
		cfg[12] = mk(cele_pkg::T_FLASH, 3, 0, 0, 0, 2);
		cfg[13] = mk(cele_pkg::T_RESET, cele_pkg::SRC_LAMP, 0, 0, 0, 0);
		cfg[13].onRel = cele_pkg::R_GT;
		cfg[13].offRel = cele_pkg::R_LT;
		cfg[13].offVal = cele_pkg::LAMP_ON;
		cfg[14] = mk(cele_pkg::T_CLOCK, 0, 0, 0, 0, 0);
		cfg[15] = mk(cele_pkg::T_FOLLOW, cele_pkg::CAN_BASE, 0, 0, 0, 0);
		cfg[16] = mk(cele_pkg::T_EDLYON, 0, 5'h01, 0, 0, 1);
		cfg[17] = mk(cele_pkg::T_FOLLOW, 5, 0, 0, 0, 0);
		cfg[18] = mk(cele_pkg::T_WIPER, 4, 5'h02, 0, 17, 0);
		for (int j = 0; j < 6; j++) begin
			cfg[19 + j] = mk(cele_pkg::T_FOLLOW, 0, 0, 0, 0, 0);
			cfg[19 + j].onRel = cele_pkg::cele_rel_t'(j);
			cfg[19 + j].offRel = cele_pkg::cele_rel_t'(5 - j);
			cfg[19 + j].onVal = 16'h0002;
			cfg[19 + j].offVal = 16'h0002;
		end
		cfg[25] = mk(cele_pkg::T_ALWAYS, 0, 0, 0, 0, 0);
		repeat (20) @(negedge ref_clk);
		rstn = 1'b1;
		@(negedge ref_clk);
		cfgWe = 1'b1;
		for (int i = 0; i < 26; i++) begin
			cfgAddr = (i == 25) ? 9'h1ff : 9'(i);
			cfgData = cfg[i];
			@(negedge ref_clk);
		end
		cfgWe = 1'b0;
		for (int k = 0; k < 8; k++) begin
			s0 = $random(seed) & 3;
			s1 = $random(seed) & 3;
			s2 = (k == 0 || k == 2 || k == 5);
			s3 = k < 5;
			s4 = k < 2;
			s5 = k >= 4;
			srcVal[0] = 16'(s0);
			srcVal[1] = 16'(s1);
			srcVal[2] = {15'h0000, s2};
			srcVal[3] = {15'h0000, s3};
			srcVal[4] = {15'h0000, s4};
			srcVal[5] = {15'h0000, s5};
			timeOfDay = 17'(k * 5);
			canAlive = k < 4;
			faultSet = (k == 5) ? 32'h00000005 : '0;
			a = s0 != 0;
			b = s1 != 0;
			if (s2 && !p2)
				tg = !tg;
			p2 = s2;
			dc = s3 ? dc + 1 : 0;
			oc = s3 ? 0 : oc + 1;
			seen = seen | s3;
			dOff = s3 || (seen && oc < 3);
			fl = s3 && (fp % 4 < 2);
			fp = s3 ? fp + 1 : 0;
			wr = s4 || (wr && !s5);
			if (k == 5 || k == 6)
				rstQ.push_back(32'h00000005);
			push(0, a);
			push(1, b);
			push(2, a & b);
			push(3, a | b);
			push(4, !(a | b));
			push(5, a ^ b);
			push(6, !a);
			push(7, 2'h1);
			push(513, b ? 2'h2 : {1'b0, a});
			push(9, tg);
			push(10, dc >= 3);
			push(11, dOff);
			push(12, fl);
			push(13, k == 5 || k == 6);
			push(512, k == 5);
			push(14, k == 2 || k == 3);
			if (k < 4)
				push(15, 2'h0);
			if (k > 5)
				push(15, 2'h1);
			push(16, a);
			push(514, wr);
			for (int j = 0; j < 6; j++)
				push(19 + j, cmp(j, s0));
			push(25, 2'h0);
			push(511, 2'h1);
			wait_busy(1'b1);
			wait_busy(1'b0);
			@(negedge ref_clk);
		end
		`CHK("restart count", 0, rstQ.size())
		finish_test();
	end
endmodule // cele_engine_tb_top
